// [hw/awf_pkg.sv]
// package: sizes, register map and modes of the width-converting fifo
package awf_pkg;
   // write port geometry; read geometry is derived from the ratio
   localparam int WR_W = 32;
   localparam int WR_DEPTH = 512;
   localparam int WR_AW = 9;
   // ratio select: 0..3 = 16:1..2:1, 4 = 1:1, 5..8 = 1:2..1:16
   localparam int RATIO_SEL = 3;
   localparam int RATIO_MID = 4;
   localparam bit WIDE_WR = RATIO_SEL < RATIO_MID;
   localparam int LR = WIDE_WR ? RATIO_MID - RATIO_SEL : RATIO_SEL - RATIO_MID;
   localparam int RD_W = WIDE_WR ? WR_W >> LR : WR_W << LR;
   localparam int LUW = WIDE_WR ? LR : 0;
   localparam int LUR = WIDE_WR ? 0 : LR;
   localparam int UNIT = WR_W >> LUW;
   localparam int UW = 1 << LUW;
   localparam int UR = 1 << LUR;
   localparam int UA = WR_AW + LUW;
   localparam int UNITS = 1 << UA;
   localparam int PW = UA + 1;
   localparam int WWW = PW - LUW;
   localparam int RWW = PW - LUR;
   localparam int WCW = WR_AW;
   localparam int RCW = UA - LUR;
   localparam int RD_DEPTH = UNITS >> LUR;
   // crossing pipeline
   localparam int SYNC_STAGES = 3;
   localparam int SYNC_TAP = 1;
   localparam int SYNC_TAP_PIPE = 2;
   localparam logic [2:0] BUSY_CYC = 3'h4;
   // register bus
   localparam int AXI_AW = 8;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_PF_TH = 8'h04;
   localparam logic [7:0] ADDR_PE_TH = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_COUNT = 8'h10;
   localparam int CTRL_DUAL = 0;
   localparam int CTRL_PIPE = 1;
   localparam int CTRL_OREG = 2;
   localparam int CTRL_PF = 3;
   localparam int CTRL_PE = 5;
   localparam int TH_NEG = 16;
   localparam int CNT_RD = 16;
   localparam logic [31:0] CTRL_MASK = 32'h0000_007f;
   localparam logic [31:0] CTRL_RST = 32'h0000_002e;
   localparam logic [31:0] PF_MASK = 32'h03ff_03ff;
   localparam logic [31:0] PF_RST = 32'h0200_0200;
   localparam logic [31:0] PE_MASK = 32'h07ff_07ff;
   localparam logic [31:0] PE_RST = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      AWF_TH_NONE = 2'b00,
      AWF_TH_SINGLE = 2'b01,
      AWF_TH_DUAL = 2'b10
   } awf_th_e;
   typedef enum logic [2:0] {
      AWF_SEL_CTRL = 3'b000,
      AWF_SEL_PF = 3'b001,
      AWF_SEL_PE = 3'b010,
      AWF_SEL_STAT = 3'b011,
      AWF_SEL_CNT = 3'b100,
      AWF_SEL_NONE = 3'b111
   } awf_sel_e;
endpackage

// [hw/awf_cfg_if.sv]
// interface: configuration and status between register slave and core
`timescale 1ns/100ps
interface awf_cfg_if;
   import awf_pkg::*;
   logic dual;
   logic pipe;
   logic oreg;
   awf_th_e pf_mode;
   awf_th_e pe_mode;
   logic [WWW-1:0] pf_set;
   logic [WWW-1:0] pf_clr;
   logic [RWW-1:0] pe_set;
   logic [RWW-1:0] pe_clr;
   logic [31:0] status;
   logic [31:0] counts;
   modport regs (output dual, pipe, oreg, pf_mode, pe_mode, pf_set, pf_clr,
                 pe_set, pe_clr, input status, counts);
   modport core (input dual, pipe, oreg, pf_mode, pe_mode, pf_set, pf_clr,
                 pe_set, pe_clr, output status, counts);
endinterface

// [hw/awf_ptr_sync.sv]
// module: gray-coded pointer crossing with selectable depth
`timescale 1ns/100ps
module awf_ptr_sync (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [awf_pkg::PW-1:0] bin,
   input wire logic pipe,
   output logic [awf_pkg::PW-1:0] bin_out
);
   import awf_pkg::*;

   typedef struct packed {
      logic [PW-1:0] launch;
      logic [SYNC_STAGES-1:0][PW-1:0] stg;
   } awf_sync_s;

   awf_sync_s st;
   awf_sync_s next_st;

   function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
      logic [PW-1:0] b;
      b[PW-1] = g[PW-1];
      for (int i = PW - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // launch gray code, then shift through the stages
   always_comb begin
      next_st = st;
      next_st.launch = bin ^ (bin >> 1);
      next_st.stg[0] = st.launch;
      for (int i = 1; i < SYNC_STAGES; i++) begin
         next_st.stg[i] = st.stg[i-1];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // extra stage when the pipeline option is on
   assign bin_out = gray2bin(pipe ? st.stg[SYNC_TAP_PIPE] : st.stg[SYNC_TAP]);
endmodule // awf_ptr_sync

// [hw/awf_axil_regs.sv]
// module: axi4-lite slave holding configuration, showing status
`timescale 1ns/100ps
module awf_axil_regs (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [awf_pkg::AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [awf_pkg::AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   awf_cfg_if.regs cfg
);
   import awf_pkg::*;

   typedef struct packed {
      logic aw_got;
      logic w_got;
      logic [AXI_AW-1:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [31:0] ctrl;
      logic [31:0] pf_th;
      logic [31:0] pe_th;
   } awf_regs_s;

   awf_regs_s st;
   awf_regs_s next_st;

   // address decode shared by both channels
   function automatic awf_sel_e reg_sel(input logic [AXI_AW-1:0] a);
      case (a)
         ADDR_CTRL: reg_sel = AWF_SEL_CTRL;
         ADDR_PF_TH: reg_sel = AWF_SEL_PF;
         ADDR_PE_TH: reg_sel = AWF_SEL_PE;
         ADDR_STATUS: reg_sel = AWF_SEL_STAT;
         ADDR_COUNT: reg_sel = AWF_SEL_CNT;
         default: reg_sel = AWF_SEL_NONE;
      endcase
   endfunction

   // byte-lane merge under a field mask
   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] s, input logic [31:0] m);
      logic [31:0] v;
      v = old;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            v[b*8 +: 8] = d[b*8 +: 8];
         end
      end
      return v & m;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // address and data taken in either order, response after both
   always_comb begin
      next_st = st;
      if (s_axi_awvalid && s_axi_awready) begin
         next_st.aw_got = 1'b1;
         next_st.waddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_st.w_got = 1'b1;
         next_st.wdata = s_axi_wdata;
         next_st.wstrb = s_axi_wstrb;
      end
      if (st.aw_got && st.w_got) begin
         next_st.aw_got = 1'b0;
         next_st.w_got = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = RESP_OKAY;
         case (reg_sel(st.waddr))
            AWF_SEL_CTRL: begin
               next_st.ctrl = merge(st.ctrl, st.wdata, st.wstrb, CTRL_MASK);
            end
            AWF_SEL_PF: begin
               next_st.pf_th = merge(st.pf_th, st.wdata, st.wstrb, PF_MASK);
            end
            AWF_SEL_PE: begin
               next_st.pe_th = merge(st.pe_th, st.wdata, st.wstrb, PE_MASK);
            end
            AWF_SEL_STAT, AWF_SEL_CNT: begin
               next_st.bresp = RESP_OKAY; // read-only, write ignored
            end
            default: begin
               next_st.bresp = RESP_SLVERR;
            end
         endcase
      end
      if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end
      // read channel
      if (s_axi_arvalid && s_axi_arready) begin
         next_st.rvalid = 1'b1;
         next_st.rresp = RESP_OKAY;
         case (reg_sel(s_axi_araddr))
            AWF_SEL_CTRL: next_st.rdata = st.ctrl;
            AWF_SEL_PF: next_st.rdata = st.pf_th;
            AWF_SEL_PE: next_st.rdata = st.pe_th;
            AWF_SEL_STAT: next_st.rdata = cfg.status;
            AWF_SEL_CNT: next_st.rdata = cfg.counts;
            default: begin
               next_st.rdata = '0;
               next_st.rresp = RESP_SLVERR;
            end
         endcase
      end else if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '{ctrl: CTRL_RST, pf_th: PF_RST, pe_th: PE_RST, default: '0};
      end else begin
         st <= next_st;
      end
   end

   // handshake and configuration outputs
   assign s_axi_awready = !st.aw_got && !st.bvalid;
   assign s_axi_wready = !st.w_got && !st.bvalid;
   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp = st.bresp;
   assign s_axi_arready = !st.rvalid;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rdata = st.rdata;
   assign s_axi_rresp = st.rresp;
   assign cfg.dual = st.ctrl[CTRL_DUAL];
   assign cfg.pipe = st.ctrl[CTRL_PIPE];
   assign cfg.oreg = st.ctrl[CTRL_OREG];
   assign cfg.pf_mode = awf_th_e'(st.ctrl[CTRL_PF +: 2]);
   assign cfg.pe_mode = awf_th_e'(st.ctrl[CTRL_PE +: 2]);
   assign cfg.pf_set = st.pf_th[WWW-1:0];
   assign cfg.pf_clr = st.pf_th[TH_NEG +: WWW];
   assign cfg.pe_set = st.pe_th[RWW-1:0];
   assign cfg.pe_clr = st.pe_th[TH_NEG +: RWW];
endmodule // awf_axil_regs

// [hw/awf_fifo.sv]
// module: width-converting fifo core with flags, counts and register bus
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
// Summary of operation
// - write reaches read flags after 1+2 cycles
// - own-side flags update on the request edge
// - pipeline option adds one receiving cycle
// - read reaches write flags after 1+2(3)
// - single clock: everything updates on request edge
// - output register delays data and valid once
// - read width and depth derive from ratio
// - wide entry freed after ratio reads
// - wide read word built from ratio writes
// - prog full sets at threshold, hysteresis optional
// - prog empty sets at threshold, hysteresis optional
// - prog flags exist only when mode selected
// - each prog flag uses own-side count
// - one reset clears pointers and flags
// - counts sized log2 of depth
// - count reads zero when full
// - crossed flags follow synchronised count
// - write while full dropped, overflow next
// - read while empty ignored, underflow next
// - almost flags at one slot or word
// - busy held four cycles after a switch into dual clock, not after a switch to single
module awf_fifo (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [awf_pkg::AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [awf_pkg::AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic wr_en,
   input wire logic [awf_pkg::WR_W-1:0] wr_data,
   output logic full,
   output logic almost_full,
   output logic prog_full,
   output logic wr_ack,
   output logic overflow,
   output logic [awf_pkg::WCW-1:0] wr_count,
   input wire logic rd_en,
   output logic [awf_pkg::RD_W-1:0] rd_data,
   output logic empty,
   output logic almost_empty,
   output logic prog_empty,
   output logic rd_valid,
   output logic underflow,
   output logic [awf_pkg::RCW-1:0] rd_count,
   output logic rst_busy
);
   import awf_pkg::*;

   localparam logic [WWW-1:0] W_FULL = WWW'(WR_DEPTH);
   localparam logic [WWW-1:0] W_ONE = WWW'(1);
   localparam logic [RWW-1:0] R_ONE = RWW'(1);
   localparam logic [PW-1:0] P_UW = PW'(UW);
   localparam logic [PW-1:0] P_UR = PW'(UR);
   localparam logic [PW-1:0] P_WMASK = PW'(UW - 1);

   typedef struct packed {
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic wr_ack;
      logic overflow;
      logic underflow;
      logic vld0;
      logic vld1;
      logic [RD_W-1:0] rq0;
      logic [RD_W-1:0] rq1;
      logic pf;
      logic pe;
      logic dual_q;
      logic [2:0] busy;
      logic [UNITS-1:0][UNIT-1:0] mem;
   } awf_core_s;

   awf_core_s st;
   awf_core_s next_st;
   awf_cfg_if cfg();

   logic [PW-1:0] wp_rd;
   logic [PW-1:0] rp_wr;
   logic [PW-1:0] rp_w;
   logic [PW-1:0] wp_r;
   logic [WWW-1:0] wr_words;
   logic [RWW-1:0] rd_words;
   logic [UA-1:0] wp_idx;
   logic [UA-1:0] rp_idx;
   logic wr_acc;
   logic rd_acc;
   logic mode_chg;
   logic pf_now;
   logic pe_now;

   ////////////////////////////////////////////////////////////////////////
   // register slave and pointer crossings
   awf_axil_regs u_regs (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .cfg(cfg)
   );

   awf_ptr_sync u_wp_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .bin(st.wp),
      .pipe(cfg.pipe),
      .bin_out(wp_rd)
   );

   awf_ptr_sync u_rp_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .bin(st.rp),
      .pipe(cfg.pipe),
      .bin_out(rp_wr)
   );

   ////////////////////////////////////////////////////////////////////////
   // each side sees the other's pointer raw or synchronised
   assign rp_w = cfg.dual ? rp_wr : st.rp;
   assign wp_r = cfg.dual ? wp_rd : st.wp;
   // partly read entry still occupies a write slot
   assign wr_words = WWW'((st.wp >> LUW) - (rp_w >> LUW));
   // partly built read word is not yet readable
   assign rd_words = RWW'((wp_r >> LUR) - (st.rp >> LUR));
   assign wp_idx = st.wp[UA-1:0];
   assign rp_idx = st.rp[UA-1:0];
   assign mode_chg = cfg.dual != st.dual_q;

   // flags straight from the updated pointers
   assign full = wr_words == W_FULL;
   assign almost_full = wr_words == W_FULL - W_ONE;
   assign empty = rd_words == '0;
   assign almost_empty = rd_words == R_ONE;
   assign wr_acc = wr_en && !full && !rst_busy;
   assign rd_acc = rd_en && !empty && !rst_busy;

   // threshold flags with optional hysteresis, each on its own count
   always_comb begin
      pf_now = 1'b0;
      pe_now = 1'b0;
      case (cfg.pf_mode)
         AWF_TH_SINGLE: pf_now = wr_words >= cfg.pf_set;
         AWF_TH_DUAL: begin
            pf_now = st.pf ? wr_words >= cfg.pf_clr : wr_words >= cfg.pf_set;
         end
         default: pf_now = 1'b0;
      endcase
      case (cfg.pe_mode)
         AWF_TH_SINGLE: pe_now = rd_words <= cfg.pe_set;
         AWF_TH_DUAL: begin
            pe_now = st.pe ? rd_words <= cfg.pe_clr : rd_words <= cfg.pe_set;
         end
         default: pe_now = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // storage, pointers, acknowledges and read pipeline
   always_comb begin
      next_st = st;
      next_st.pf = pf_now;
      next_st.pe = pe_now;
      next_st.wr_ack = wr_acc;
      next_st.overflow = wr_en && full;
      next_st.underflow = rd_en && empty;
      if (wr_acc) begin
         // lowest slice goes to the lowest unit address
         for (int k = 0; k < UW; k++) begin
            next_st.mem[UA'(wp_idx + k)] = wr_data[k*UNIT +: UNIT];
         end
         next_st.wp = st.wp + P_UW;
      end
      if (rd_acc) begin
         for (int k = 0; k < UR; k++) begin
            next_st.rq0[k*UNIT +: UNIT] = st.mem[UA'(rp_idx + k)];
         end
         next_st.rp = st.rp + P_UR;
      end
      next_st.vld0 = rd_acc;
      next_st.vld1 = st.vld0;
      next_st.rq1 = st.rq0;
      next_st.dual_q = cfg.dual;
      // a clock-mode change restarts both sides
      if (mode_chg) begin
         next_st.wp = '0;
         next_st.rp = '0;
         next_st.busy = cfg.dual ? BUSY_CYC : '0;
      end else if (st.busy != '0) begin
         next_st.busy = st.busy - 3'h1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign prog_full = pf_now;
   assign prog_empty = pe_now;
   assign wr_ack = st.wr_ack;
   assign overflow = st.overflow;
   assign underflow = st.underflow;
   assign rd_valid = cfg.oreg ? st.vld1 : st.vld0;
   assign rd_data = cfg.oreg ? st.rq1 : st.rq0;
   assign wr_count = wr_words[WCW-1:0];
   assign rd_count = rd_words[RCW-1:0];
   assign rst_busy = st.dual_q && st.busy != '0;
   assign cfg.status = 32'({rst_busy, prog_empty, almost_empty, empty,
                            prog_full, almost_full, full});
   assign cfg.counts = (32'(rd_count) << CNT_RD) | 32'(wr_count);

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_overflow;
      wr_en && full && !mode_chg |=> overflow && !wr_ack && $stable(st.wp);
   endproperty
   a_overflow: assert property (p_overflow) else $error("overflow bad");

   property p_underflow;
      rd_en && empty && !mode_chg |=> underflow && !st.vld0 && $stable(st.rp);
   endproperty
   a_underflow: assert property (p_underflow) else $error("underflow bad");

   property p_single_lat;
      !cfg.dual && wr_acc && !rd_acc && !mode_chg
         |=> wr_words == $past(wr_words) + W_ONE;
   endproperty
   a_single_lat: assert property (p_single_lat) else $error("count late");

   property p_w2r;
      cfg.dual && !cfg.pipe && !mode_chg && wr_acc && empty && wp_rd == st.wp
         |=> empty [*3] ##1 !empty;
   endproperty
   a_w2r: assert property (p_w2r) else $error("empty latency");

   property p_w2r_pipe;
      cfg.dual && cfg.pipe && !mode_chg && wr_acc && empty && wp_rd == st.wp
         |=> empty [*4] ##1 !empty;
   endproperty
   a_w2r_pipe: assert property (p_w2r_pipe) else $error("pipe latency");

   property p_r2w;
      cfg.dual && !cfg.pipe && !mode_chg && full && rd_acc && rp_wr == st.rp
         && ((st.rp + P_UR) & P_WMASK) == '0 |=> full [*3] ##1 !full;
   endproperty
   a_r2w: assert property (p_r2w) else $error("full latency");

   property p_pfull;
      cfg.pf_mode == AWF_TH_SINGLE |-> prog_full == (wr_words >= cfg.pf_set);
   endproperty
   a_pfull: assert property (p_pfull) else $error("prog full bad");

   property p_pempty;
      cfg.pe_mode == AWF_TH_SINGLE |-> prog_empty == (rd_words <= cfg.pe_set);
   endproperty
   a_pempty: assert property (p_pempty) else $error("prog empty bad");

   property p_full_cnt;
      full |-> wr_count == '0 && !almost_full;
   endproperty
   a_full_cnt: assert property (p_full_cnt) else $error("full count");

   property p_oreg;
      rd_acc && cfg.oreg && !mode_chg && !st.vld0
         |=> !st.vld1 ##0 st.vld0 ##1 rd_valid;
   endproperty
   a_oreg: assert property (p_oreg) else $error("valid timing");

   property p_busy;
      $rose(st.dual_q) |-> rst_busy [*4] ##1 !rst_busy;
   endproperty
   a_busy: assert property (p_busy) else $error("busy length");

   c_full: cover property (wr_acc ##1 full);
   c_ovf: cover property (overflow);
   c_unf: cover property (underflow);
   c_dual: cover property (cfg.dual && wr_acc && empty ##4 !empty);
endmodule // awf_fifo

// [dv/awf_stream_model.sv]
// partner: producer and consumer on the stream ports
`timescale 1ns/100ps
module awf_stream_model (
   input wire logic aclk,
   output logic wr_en,
   output logic [awf_pkg::WR_W-1:0] wr_data,
   output logic rd_en
);
   import awf_pkg::*;
   initial begin
      wr_en = 1'b0;
      wr_data = '0;
      rd_en = 1'b0;
   end
   // one write held for one edge, data scrambled once released
   task automatic push(input logic [WR_W-1:0] d);
      @(posedge aclk);
      wr_en <= 1'b1;
      wr_data <= d;
      @(posedge aclk);
      wr_en <= 1'b0;
      wr_data <= ~d;
   endtask
   // one read request held for one edge
   task automatic pull();
      @(posedge aclk);
      rd_en <= 1'b1;
      @(posedge aclk);
      rd_en <= 1'b0;
   endtask
endmodule // awf_stream_model

// [dv/awf_fifo_tb.sv]
// bench: register bus, stream flags, ordering and refusals
`timescale 1ns/100ps
module awf_fifo_tb;
   import awf_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, v;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, full, almost_full, prog_full, wr_ack, overflow;
   logic empty, almost_empty, prog_empty, rd_valid, underflow, rst_busy;
   logic wr_en, rd_en;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [WR_W-1:0] wr_data;
   logic [WCW-1:0] wr_count;
   logic [RD_W-1:0] rd_data;
   logic [RCW-1:0] rd_count;
   int mismatches = 0, comparisons = 0;
   always #2 aclk = ~aclk;
   awf_fifo awf_fifo_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wr_en, .wr_data, .full,
      .almost_full, .prog_full, .wr_ack, .overflow, .wr_count, .rd_en,
      .rd_data, .empty, .almost_empty, .prog_empty, .rd_valid, .underflow,
      .rd_count, .rst_busy);
   awf_stream_model awf_stream_model_i (.aclk, .wr_en, .wr_data, .rd_en);
   ////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // bus write, both channels offered together
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      if (n == 40) begin
         mismatches++;
         stop_test();
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   // bus read
   task automatic axi_rd(input logic [7:0] a);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      if (n == 40) begin
         mismatches++;
         stop_test();
      end
      v = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      #1;
      chk(empty, 1);
      chk(prog_empty, 1);
      chk({full, prog_full, rd_count}, 0);
      axi_rd(ADDR_CTRL);
      chk(v, CTRL_RST);
      axi_rd(8'h40);
      chk(r, RESP_SLVERR);
      axi_wr(8'h40, 32'h0);
      chk(r, RESP_SLVERR);
   endtask
   task automatic t_flow();
      awf_stream_model_i.push(32'hbeef_1234);
      #1;
      chk({wr_ack, empty, wr_count}, {2'b10, 9'h001});
      chk(rd_count, 2);
      awf_stream_model_i.pull();
      #1;
      chk({rd_valid, almost_empty, rd_count}, {2'b01, 10'h001});
      chk(wr_count, 1);
      @(posedge aclk);
      #1;
      chk({rd_valid, rd_data}, {1'b1, 16'h1234});
      awf_stream_model_i.pull();
      #1;
      chk({empty, wr_count}, {1'b1, 9'h000});
      @(posedge aclk);
      #1;
      chk(rd_data, 16'hbeef);
   endtask
   task automatic t_under();
      awf_stream_model_i.pull();
      #1;
      chk(underflow, 1);
   endtask
   task automatic t_full();
      for (int i = 0; i < 512; i++) begin
         if (i == 511) begin
            #1;
            chk({almost_full, wr_count}, {1'b1, 9'h1ff});
         end
         awf_stream_model_i.push({16'(i) ^ 16'ha5a5, 16'(i)});
      end
      #1;
      chk({full, prog_full, almost_full, wr_count}, 12'hc00);
      awf_stream_model_i.push(32'hdead_dead);
      #1;
      chk({overflow, wr_ack}, 2'b10);
      for (int i = 0; i < 512; i++) begin
         awf_stream_model_i.pull();
         @(posedge aclk);
         #1;
         chk(rd_data, 16'(i));
         awf_stream_model_i.pull();
         @(posedge aclk);
         #1;
         chk(rd_data, 16'(i) ^ 16'ha5a5);
      end
      chk(empty, 1);
   endtask
   task automatic t_dual();
      int n;
      axi_wr(ADDR_CTRL, CTRL_RST | 32'h1);
      #1;
      chk(rst_busy, 1);
      for (n = 0; n < 20 && rst_busy !== 1'b0; n++) @(posedge aclk);
      chk(n < 20, 1);
      awf_stream_model_i.push(32'h5678_9abc);
      #1;
      chk({empty, wr_count}, {1'b1, 9'h001});
      repeat (3) @(posedge aclk);
      #1;
      chk(empty, 1);
      @(posedge aclk);
      #1;
      chk({empty, rd_count}, 11'h002);
      awf_stream_model_i.pull();
      awf_stream_model_i.pull();
      #1;
      chk(empty, 1);
      repeat (3) @(posedge aclk);
      #1;
      chk(wr_count, 1);
      @(posedge aclk);
      #1;
      chk(wr_count, 0);
   endtask
   // dual clock, no pipe, no out reg, prog full with hysteresis
   task automatic t_hyst();
      axi_wr(ADDR_PF_TH, 32'h0001_0002);
      axi_wr(ADDR_CTRL, 32'h0000_0031);
      awf_stream_model_i.push(32'h1111_2222);
      awf_stream_model_i.push(32'h3333_4444);
      #1;
      chk({prog_full, wr_count, empty}, {1'b1, 9'h002, 1'b1});
      @(posedge aclk);
      #1;
      chk({empty, rd_count}, 11'h002);
      awf_stream_model_i.pull();
      #1;
      chk({rd_valid, rd_data}, {1'b1, 16'h2222});
      awf_stream_model_i.pull();
      repeat (2) @(posedge aclk);
      #1;
      chk(wr_count, 2);
      @(posedge aclk);
      #1;
      chk({prog_full, wr_count}, {1'b1, 9'h001});
      awf_stream_model_i.pull();
      awf_stream_model_i.pull();
      repeat (3) @(posedge aclk);
      #1;
      chk({prog_full, wr_count}, 10'h000);
      repeat (512) awf_stream_model_i.push(32'h0);
      #1;
      chk({full, wr_count}, 10'h200);
      awf_stream_model_i.pull();
      repeat (3) @(posedge aclk);
      awf_stream_model_i.pull();
      repeat (3) @(posedge aclk);
      #1;
      chk(full, 0);
   endtask
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      t_reset();
      t_flow();
      t_under();
      t_full();
      t_dual();
      t_hyst();
      stop_test();
   end
endmodule // awf_fifo_tb
